// >>> bench/qdw_link_monitor.sv
/*
  Checker of the three-wire link between serial master and converter.
  Assumes it sees the link wires sampled on the system clock of the master.
*/
`timescale 1ns/1ps
module qdw_link_monitor (
  // clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // link wires
  input  wire logic sclk,
  input  wire logic syncN,
  input  wire logic din
);
  import qdw_pkg::*;

  // ----------------------------------------------------------------
  // falling edges seen in the current frame
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] fallCnt_reg;
  logic [CNT_W-1:0] fallCnt_next;
  logic             sclk_reg;

  always_comb begin
    fallCnt_next = fallCnt_reg;
    if (syncN) begin
      fallCnt_next = CNT_ZERO;
    end else if (sclk_reg && !sclk) begin
      fallCnt_next = fallCnt_reg + CNT_ONE;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      fallCnt_reg <= CNT_ZERO;
      sclk_reg    <= 1'b1;
    end else begin
      fallCnt_reg <= fallCnt_next;
      sclk_reg    <= sclk;
    end
  end

  // ----------------------------------------------------------------
  // link properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_idle_sclk_high: assert property (syncN |-> sclk)
    else $error("serial clock low outside a frame");
  a_sync_lead: assert property ($fell(syncN) |-> sclk [*3])
    else $error("serial clock fell too soon after frame start");
  a_low_half: assert property ($fell(sclk) |-> !sclk [*3] ##1 sclk)
    else $error("serial clock low half not three cycles");
  a_high_half: assert property ($rose(sclk) && !syncN |-> sclk [*3])
    else $error("serial clock high half too short");
  a_din_hold_low: assert property (!sclk |-> $stable(din))
    else $error("data changed while serial clock low");
  a_fall_limit: assert property (fallCnt_reg <= CNT_FULL)
    else $error("more than sixteen falls in a frame");
  a_frame_trail: assert property ($rose(syncN) |-> $past(sclk, 4) && $past(sclk, 1))
    else $error("frame ended without trailing high clock");
  a_frame_gap: assert property ($rose(syncN) |-> syncN [*3])
    else $error("frame sync gap shorter than three cycles");
endmodule : qdw_link_monitor

// >>> bench/quad_dac_serial_write_port_tb.sv
/*
  Self-checking bench: master and converter joined over one link, plus a
  second converter whose link the bench drives to break framing on purpose.
  Assumes the package, interface and both design ends are compiled first.
*/
`timescale 1ns/1ps
module quad_dac_serial_write_port_tb;
  import qdw_pkg::*;

  logic                               clk      = 1'b0;
  logic                               rstn     = 1'b0;
  logic [REG_ADDR_W-1:0]              regAddr  = 8'h00;
  logic [REG_DATA_W-1:0]              regWdata = 32'h00000000;
  logic                               regWr    = 1'b0;
  logic                               regRd    = 1'b0;
  logic [REG_DATA_W-1:0]              regRdata;
  logic [CHANNELS-1:0][CODE_BITS-1:0] codeA;
  logic [CHANNELS-1:0][CODE_BITS-1:0] codeB;
  qdw_term_t                          termA;
  qdw_term_t                          termB;
  logic                               updA;
  logic                               updB;
  logic [FRAME_CNT_W-1:0]             wordsA;
  logic [FRAME_CNT_W-1:0]             wordsB;
  logic [CODE_BITS-1:0]               holdE [CHANNELS];
  logic [CODE_BITS-1:0]               outE  [CHANNELS];
  qdw_term_t                          termE = TERM_ACTIVE;
  logic [FRAME_CNT_W-1:0]             nW    = 8'h00;
  logic [31:0]                        rdv;
  logic [FRAME_CNT_W-1:0]             nF    = 8'h00;
  int                                 nUpdA = 0;
  int                                 nUpdB = 0;
  int                                 nUpdE = 0;
  int                                 err_total = 0;
  int                                 cmp_count = 0;

  qdw_link_if linkA ();
  qdw_link_if linkB ();

  always #2.5 clk = ~clk;

  // update strobes are one-cycle pulses, so each one is counted once
  always @(posedge clk) begin
    if (updA === 1'b1) begin
      nUpdA <= nUpdA + 1;
    end
    if (updB === 1'b1) begin
      nUpdB <= nUpdB + 1;
    end
  end

  qdw_host u_qdw_host (.link(linkA.host), .clk(clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
                       .regWr(regWr), .regRd(regRd), .regRdata(regRdata));
  qdw_device u_qdw_device (.link(linkA.dev), .clk(clk), .rstn(rstn), .chanCode(codeA), .pdTerm(termA),
                           .updateStrobe(updA), .wordsTaken(wordsA));
  // second converter: the bench plays a faulty master on its link
  qdw_device u_qdw_device_b (.link(linkB.dev), .clk(clk), .rstn(rstn), .chanCode(codeB), .pdTerm(termB),
                             .updateStrobe(updB), .wordsTaken(wordsB));
  qdw_link_monitor u_qdw_link_monitor (.clk(clk), .rstn(rstn), .sclk(linkA.sclk), .syncN(linkA.syncN),
                                       .din(linkA.din));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 rdv = regRdata;
  endtask : rd

  // expected converter state after one complete word
  task automatic model(input logic [15:0] v);
    nW++;
    if (v[13:12] != 2'h0) begin
      nUpdE++;
    end
    case (v[13:12])
      2'h0: holdE[v[15:14]] = v[11:2];
      2'h1: begin
        holdE[v[15:14]] = v[11:2];
        outE[v[15:14]]  = v[11:2];
        termE           = TERM_ACTIVE;
      end
      2'h2: begin
        holdE[v[15:14]] = v[11:2];
        outE            = holdE;
        termE           = TERM_ACTIVE;
      end
      default: termE = (v[15:14] == 2'h0) ? TERM_2K5 : (v[15:14] == 2'h1) ? TERM_100K : TERM_HIZ;
    endcase
  endtask : model

  task automatic compare();
    for (int i = 0; i < CHANNELS; i++) begin
      chk(codeA[i], outE[i]);
    end
    chk(termA, termE);
    chk(wordsA, nW);
    chk(nUpdA, nUpdE);
  endtask : compare

  // one frame through the register port; dup tries a refused second word
  task automatic frame(input logic [15:0] v, input logic [4:0] len, input logic dup);
    int n;
    n = 0;
    wr(REG_LEN, {27'h0, len});
    wr(REG_WORD, {16'h0, v});
    if (dup) begin
      wr(REG_WORD, {16'h0, ~v});
    end
    rdv = 32'h1;
    while (rdv[STAT_BUSY_BIT] && n < 100) begin
      rd(REG_STATUS);
      n++;
    end
    chk(rdv[STAT_BUSY_BIT], 1'b0);
    nF++;
    chk(rdv[STAT_CNT_MSB:STAT_CNT_LSB], nF);
    rd(REG_LEN);
    chk(rdv, {27'h0, len});
    if (dup) begin
      rd(REG_WORD);
      chk(rdv, {16'h0, v});
    end
    repeat (4) @(posedge clk);
    // a length of zero or above sixteen still sends a full word
    if (len == 5'h00 || len >= 5'h10) begin
      model(v);
    end
    compare();
  endtask : frame

  // faulty master on the second link, edges at a 6 ns period
  task automatic sendB(input logic [15:0] v, input int n);
    linkB.syncN = 1'b0;
    #7;
    for (int i = 0; i < n; i++) begin
      linkB.din = (i < 16) ? v[15-i] : 1'($urandom);
      #3 linkB.sclk = 1'b0;
      #3 linkB.sclk = 1'b1;
    end
    #30 linkB.syncN = 1'b1;
    linkB.din = ~linkB.din;
    #30;
  endtask : sendB

  task automatic test_done();
    if (err_total == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : test_done

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(65167));
    linkB.sclk  = 1'b1;
    linkB.syncN = 1'b0;
    linkB.din   = 1'b0;
    // a real rising edge clears the link-domain bit counter of the second converter
    #1 linkB.syncN = 1'b1;
    for (int i = 0; i < CHANNELS; i++) begin
      holdE[i] = CODE_ZERO;
      outE[i]  = CODE_ZERO;
    end
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    chk(codeA, 40'h0);
    chk(termA, TERM_ACTIVE);
    rd(8'h0C);
    chk(rdv, 32'h0);
    frame({2'h2, 2'h0, 10'h155, 2'h0}, 5'h10, 1'b0);
    frame({2'h0, 2'h2, 10'h2AA, 2'h0}, 5'h10, 1'b0);
    for (int c = 0; c < CHANNELS; c++) begin
      frame({c[1:0], 2'h1, 10'($urandom), 2'h0}, 5'h10, 1'b0);
    end
    for (int t = 0; t < 4; t++) begin
      frame({t[1:0], 2'h3, 10'($urandom), 2'h0}, 5'h10, 1'b0);
    end
    frame({2'h1, 2'h1, 10'h3FF, 2'h3}, 5'h0F, 1'b0);
    frame({2'h3, 2'h1, 10'h001, 2'h0}, 5'h10, 1'b1);
    frame({2'h2, 2'h1, 10'h0F0, 2'h0}, 5'h00, 1'b0);
    frame({2'h0, 2'h1, 10'h10F, 2'h0}, 5'h1F, 1'b0);
    for (int k = 0; k < 16; k++) begin
      frame(16'($urandom), 5'h10, 1'b0);
    end
    sendB({2'h1, 2'h1, 10'h2C3, 2'h0}, 20);
    chk(codeB[1], 10'h2C3);
    chk(wordsB, 8'h01);
    sendB({2'h1, 2'h1, 10'h05A, 2'h0}, 9);
    chk(codeB[1], 10'h2C3);
    chk(wordsB, 8'h01);
    sendB({2'h3, 2'h1, 10'h301, 2'h1}, 16);
    chk(codeB[3], 10'h301);
    chk(wordsB, 8'h02);
    chk(nUpdB, 40'h2);
    chk(termB, TERM_ACTIVE);
    test_done();
  end

  // hang guard: the whole sequence needs well under this span
  initial begin
    #300000;
    err_total++;
    test_done();
  end
endmodule : quad_dac_serial_write_port_tb

// >>> pkg/qdw_link_if.sv
/*
  Three-wire serial link between the serial master and the converter.
  Assumes the master drives every wire and the converter only listens.
*/
`timescale 1ns/1ps
interface qdw_link_if;
  logic sclk;
  logic syncN;
  logic din;

  modport host (
    output sclk,
    output syncN,
    output din
  );

  modport dev (
    input  sclk,
    input  syncN,
    input  din
  );
endinterface : qdw_link_if

// >>> pkg/qdw_pkg.sv
/*
  Shared constants and types of the quad converter serial write port:
  command word layout, update modes, power-down terminations, serial timing
  and the register map of the serial master.
  Assumes both ends and the bench compile this package first.
*/
package qdw_pkg;

  // ----------------------------------------------------------------
  // command word
  // ----------------------------------------------------------------
  localparam int WORD_BITS    = 16;
  localparam int CODE_BITS    = 10;
  localparam int CHANNELS     = 4;
  localparam int ADDR_W       = 2;
  localparam int ADDR_MSB     = 15;
  localparam int ADDR_LSB     = 14;
  localparam int MODE_MSB     = 13;
  localparam int MODE_LSB     = 12;
  localparam int CODE_MSB     = 11;
  localparam int CODE_LSB     = 2;
  localparam int CNT_W        = 5;
  localparam int CNT_DONE_BIT = 4;
  localparam logic [CNT_W-1:0]     CNT_ZERO  = 5'h00;
  localparam logic [CNT_W-1:0]     CNT_ONE   = 5'h01;
  localparam logic [CNT_W-1:0]     CNT_FULL  = 5'h10;
  localparam logic [CODE_BITS-1:0] CODE_ZERO = 10'h000;

  typedef enum logic [1:0] {
    MODE_WRITE,
    MODE_WRITE_UPD,
    MODE_ALL_UPD,
    MODE_POWER_DOWN
  } qdw_mode_t;

  typedef enum logic [1:0] {
    TERM_ACTIVE,
    TERM_2K5,
    TERM_100K,
    TERM_HIZ
  } qdw_term_t;

  // ----------------------------------------------------------------
  // serial timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ       = 200;
  localparam int SCLK_MAX_MHZ  = 40;
  localparam int SCLK_HALF_CYC = (CLK_MHZ + 2 * SCLK_MAX_MHZ - 1) / (2 * SCLK_MAX_MHZ);
  localparam int TRAIL_CYC     = 8;
  localparam int GAP_CYC       = SCLK_HALF_CYC;
  localparam int PHASE_W       = 4;

  // ----------------------------------------------------------------
  // serial master registers
  // ----------------------------------------------------------------
  localparam int REG_ADDR_W = 8;
  localparam int REG_DATA_W = 32;
  localparam logic [REG_ADDR_W-1:0] REG_WORD   = 8'h00;
  localparam logic [REG_ADDR_W-1:0] REG_LEN    = 8'h04;
  localparam logic [REG_ADDR_W-1:0] REG_STATUS = 8'h08;
  localparam logic [CNT_W-1:0]      LEN_RESET  = 5'h10;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_CNT_LSB  = 8;
  localparam int STAT_CNT_MSB  = 15;
  localparam int FRAME_CNT_W   = 8;

endpackage : qdw_pkg

// >>> verilog/qdw_device.sv
/*
  Converter end of the serial write port: shift register on the serial
  clock, word handover into the system clock, channel holding and output
  registers and the power-down state.
  Assumes the master holds frame sync low for some system clocks after the
  last bit, so the completed word is seen before the frame ends.
*/
// Behaviour
// - sixteen-bit input shift register takes each word
// - data sampled on falling serial clock edges
// - bits accepted only while frame sync low
// - sixteenth edge applies word, updates selected channels
// - early frame sync rise discards partial word
// - word decodes channel, mode, power-down, code
// - mode chooses simultaneous or individual channel update
// - outputs zero after reset until valid write
// - power-down offers three output terminations
// - master keeps serial clock at 40 MHz maximum
`timescale 1ns/1ps
module qdw_device (
  // serial link
  qdw_link_if.dev                                       link,
  // system clock and reset
  input  wire logic                                     clk,
  input  wire logic                                     rstn,
  // converter side
  output logic [qdw_pkg::CHANNELS-1:0][qdw_pkg::CODE_BITS-1:0] chanCode,
  output qdw_pkg::qdw_term_t                            pdTerm,
  output logic                                          updateStrobe,
  output logic [qdw_pkg::FRAME_CNT_W-1:0]               wordsTaken
);
  import qdw_pkg::*;

  // ----------------------------------------------------------------
  // link domain: shift register and bit counter
  // ----------------------------------------------------------------
  logic [WORD_BITS-1:0] shift_reg;
  logic [WORD_BITS-1:0] shift_next;
  logic [CNT_W-1:0]     bitCnt_reg;
  logic [CNT_W-1:0]     bitCnt_next;
  logic                 take;

  always_comb begin
    take        = (bitCnt_reg != CNT_FULL) && !link.syncN;
    bitCnt_next = bitCnt_reg;
    shift_next  = shift_reg;
    if (take) begin
      bitCnt_next = bitCnt_reg + CNT_ONE;
      shift_next  = {shift_reg[WORD_BITS-2:0], link.din};
    end
  end

  // frame sync high clears the count at once, so a short frame never completes
  always_ff @(negedge link.sclk or posedge link.syncN) begin
    if (link.syncN) begin
      bitCnt_reg <= CNT_ZERO;
    end else begin
      bitCnt_reg <= bitCnt_next;
    end
  end

  // data needs no reset; only a completed count ever releases it
  always_ff @(negedge link.sclk) begin
    shift_reg <= shift_next;
  end

  // ----------------------------------------------------------------
  // crossing of the completed-word level
  // ----------------------------------------------------------------
  logic doneMeta_reg;
  logic doneMeta_next;
  logic doneSync_reg;
  logic doneSync_next;
  logic donePrev_reg;
  logic donePrev_next;
  logic apply;

  always_comb begin
    doneMeta_next = bitCnt_reg[CNT_DONE_BIT];
    doneSync_next = doneMeta_reg;
    donePrev_next = doneSync_reg;
    apply         = doneSync_reg && !donePrev_reg;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      doneMeta_reg <= 1'b0;
      doneSync_reg <= 1'b0;
      donePrev_reg <= 1'b0;
    end else begin
      doneMeta_reg <= doneMeta_next;
      doneSync_reg <= doneSync_next;
      donePrev_reg <= donePrev_next;
    end
  end

  // ----------------------------------------------------------------
  // word decode
  // ----------------------------------------------------------------
  // the shift register is stable here: it stops at sixteen bits and only
  // restarts after frame sync has risen, well after the level has crossed
  logic [ADDR_W-1:0]    addrF;
  qdw_mode_t            modeF;
  logic [CODE_BITS-1:0] codeF;
  logic                 writesHold;

  always_comb begin
    addrF      = shift_reg[ADDR_MSB:ADDR_LSB];
    modeF      = qdw_mode_t'(shift_reg[MODE_MSB:MODE_LSB]);
    codeF      = shift_reg[CODE_MSB:CODE_LSB];
    writesHold = apply && (modeF != MODE_POWER_DOWN);
  end

  function automatic qdw_term_t termOf(input logic [ADDR_W-1:0] sel);
    qdw_term_t t;
    unique case (sel)
      2'h0: t = TERM_2K5;
      2'h1: t = TERM_100K;
      2'h2: t = TERM_HIZ;
      2'h3: t = TERM_HIZ;
    endcase
    return t;
  endfunction : termOf

  // ----------------------------------------------------------------
  // per-channel holding and output registers
  // ----------------------------------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : gChan
      logic [CODE_BITS-1:0] hold_reg;
      logic [CODE_BITS-1:0] hold_next;
      logic [CODE_BITS-1:0] out_reg;
      logic [CODE_BITS-1:0] out_next;
      logic                 sel;

      always_comb begin
        sel       = writesHold && (addrF == ADDR_W'(ch));
        hold_next = sel ? codeF : hold_reg;
        out_next  = out_reg;
        if (apply) begin
          unique case (modeF)
            MODE_WRITE: begin
              out_next = out_reg;
            end
            MODE_WRITE_UPD: begin
              if (sel) begin
                out_next = codeF;
              end
            end
            MODE_ALL_UPD: begin
              out_next = sel ? codeF : hold_reg;
            end
            MODE_POWER_DOWN: begin
              out_next = out_reg;
            end
          endcase
        end
      end

      always_ff @(posedge clk) begin
        if (!rstn) begin
          hold_reg <= CODE_ZERO;
          out_reg  <= CODE_ZERO;
        end else begin
          hold_reg <= hold_next;
          out_reg  <= out_next;
        end
      end

      assign chanCode[ch] = out_reg;
    end
  endgenerate

  // ----------------------------------------------------------------
  // power-down state, update strobe and word count
  // ----------------------------------------------------------------
  qdw_term_t                term_reg;
  qdw_term_t                term_next;
  logic                     strobe_reg;
  logic                     strobe_next;
  logic [FRAME_CNT_W-1:0]   count_reg;
  logic [FRAME_CNT_W-1:0]   count_next;

  always_comb begin
    term_next   = term_reg;
    strobe_next = 1'b0;
    count_next  = count_reg;
    if (apply) begin
      count_next = count_reg + FRAME_CNT_W'(1);
      unique case (modeF)
        MODE_WRITE: begin
          term_next = term_reg;
        end
        MODE_WRITE_UPD, MODE_ALL_UPD: begin
          term_next   = TERM_ACTIVE;
          strobe_next = 1'b1;
        end
        MODE_POWER_DOWN: begin
          term_next   = termOf(addrF);
          strobe_next = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      term_reg   <= TERM_ACTIVE;
      strobe_reg <= 1'b0;
      count_reg  <= '0;
    end else begin
      term_reg   <= term_next;
      strobe_reg <= strobe_next;
      count_reg  <= count_next;
    end
  end

  assign pdTerm       = term_reg;
  assign updateStrobe = strobe_reg;
  assign wordsTaken   = count_reg;

endmodule : qdw_device

// >>> verilog/qdw_host.sv
/*
  Serial master end: register port for software, frame sequencer that
  divides the system clock down into the serial clock.
  Assumes a single software master on the plain register port.
*/
`timescale 1ns/1ps
module qdw_host (
  // serial link
  qdw_link_if.host                          link,
  // system clock and reset
  input  wire logic                         clk,
  input  wire logic                         rstn,
  // register port
  input  wire logic [qdw_pkg::REG_ADDR_W-1:0] regAddr,
  input  wire logic [qdw_pkg::REG_DATA_W-1:0] regWdata,
  input  wire logic                         regWr,
  input  wire logic                         regRd,
  output logic [qdw_pkg::REG_DATA_W-1:0]    regRdata
);
  import qdw_pkg::*;

  // ----------------------------------------------------------------
  // frame sequencer
  // ----------------------------------------------------------------
  typedef enum {S_IDLE, S_HIGH, S_LOW, S_TRAIL, S_GAP} qdw_state_t;

  qdw_state_t             state_reg,  state_next;
  logic [PHASE_W-1:0]     phase_reg,  phase_next;
  logic [CNT_W-1:0]       bits_reg,   bits_next;
  logic [CNT_W-1:0]       frameLen_reg, frameLen_next;
  logic [WORD_BITS-1:0]   shift_reg,  shift_next;
  logic [WORD_BITS-1:0]   word_reg,   word_next;
  logic [CNT_W-1:0]       len_reg,    len_next;
  logic [FRAME_CNT_W-1:0] frames_reg, frames_next;
  logic                   sclk_reg,   sclk_next;
  logic                   sync_reg,   sync_next;
  logic                   din_reg,    din_next;
  logic [REG_DATA_W-1:0]  rdata_reg,  rdata_next;
  logic                   start;
  logic                   halfDone;

  always_comb begin
    start         = regWr && (regAddr == REG_WORD) && (state_reg == S_IDLE);
    halfDone      = (phase_reg == PHASE_W'(SCLK_HALF_CYC - 1));
    state_next    = state_reg;
    phase_next    = phase_reg + PHASE_W'(1);
    bits_next     = bits_reg;
    frameLen_next = frameLen_reg;
    shift_next    = shift_reg;
    word_next     = word_reg;
    len_next      = len_reg;
    frames_next   = frames_reg;
    sclk_next     = sclk_reg;
    sync_next     = sync_reg;
    din_next      = din_reg;
    if (regWr && (regAddr == REG_LEN)) begin
      len_next = regWdata[CNT_W-1:0];
    end
    unique case (state_reg)
      S_IDLE: begin
        phase_next = '0;
        if (start) begin
          word_next     = regWdata[WORD_BITS-1:0];
          sync_next     = 1'b0;
          din_next      = regWdata[WORD_BITS-1];
          shift_next    = {regWdata[WORD_BITS-2:0], 1'b0};
          bits_next     = CNT_ZERO;
          frameLen_next = ((len_reg == CNT_ZERO) || (len_reg > CNT_FULL)) ? CNT_FULL : len_reg;
          state_next    = S_HIGH;
        end
      end
      S_HIGH: begin
        if (halfDone) begin
          sclk_next  = 1'b0;
          bits_next  = bits_reg + CNT_ONE;
          phase_next = '0;
          state_next = S_LOW;
        end
      end
      S_LOW: begin
        if (halfDone) begin
          sclk_next  = 1'b1;
          phase_next = '0;
          if (bits_reg == frameLen_reg) begin
            state_next = S_TRAIL;
          end else begin
            din_next   = shift_reg[WORD_BITS-1];
            shift_next = {shift_reg[WORD_BITS-2:0], 1'b0};
            state_next = S_HIGH;
          end
        end
      end
      S_TRAIL: begin
        if (phase_reg == PHASE_W'(TRAIL_CYC - 1)) begin
          sync_next  = 1'b1;
          phase_next = '0;
          state_next = S_GAP;
        end
      end
      S_GAP: begin
        if (phase_reg == PHASE_W'(GAP_CYC - 1)) begin
          frames_next = frames_reg + FRAME_CNT_W'(1);
          state_next  = S_IDLE;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // register read
  // ----------------------------------------------------------------
  always_comb begin
    rdata_next = '0;
    if (regRd) begin
      unique case (regAddr)
        REG_WORD:   rdata_next[WORD_BITS-1:0] = word_reg;
        REG_LEN:    rdata_next[CNT_W-1:0] = len_reg;
        REG_STATUS: begin
          rdata_next[STAT_BUSY_BIT]              = (state_reg != S_IDLE);
          rdata_next[STAT_CNT_MSB:STAT_CNT_LSB]  = frames_reg;
        end
        default:    rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_reg    <= S_IDLE;
      phase_reg    <= '0;
      bits_reg     <= CNT_ZERO;
      frameLen_reg <= CNT_FULL;
      shift_reg    <= '0;
      word_reg     <= '0;
      len_reg      <= LEN_RESET;
      frames_reg   <= '0;
      sclk_reg     <= 1'b1;
      sync_reg     <= 1'b1;
      din_reg      <= 1'b0;
      rdata_reg    <= '0;
    end else begin
      state_reg    <= state_next;
      phase_reg    <= phase_next;
      bits_reg     <= bits_next;
      frameLen_reg <= frameLen_next;
      shift_reg    <= shift_next;
      word_reg     <= word_next;
      len_reg      <= len_next;
      frames_reg   <= frames_next;
      sclk_reg     <= sclk_next;
      sync_reg     <= sync_next;
      din_reg      <= din_next;
      rdata_reg    <= rdata_next;
    end
  end

  assign link.sclk  = sclk_reg;
  assign link.syncN = sync_reg;
  assign link.din   = din_reg;
  assign regRdata   = rdata_reg;

endmodule : qdw_host
